// ---- hdl/lock_detect_pkg.sv ----
// Package: register map, field layout, timing constants and carriers for the lock detector
package lock_detect_pkg;

   // ------------------------------------------------------------------
   // Register offsets (word index on the plain register port)
   // ------------------------------------------------------------------
   localparam logic [7:0] STATUS_SEL_OFS = 8'h17;
   localparam logic [7:0] LOCK_CTRL_OFS = 8'h18;
   localparam logic [7:0] DELAY_CTRL_OFS = 8'h19;
   localparam logic [7:0] LD_SEL_OFS = 8'h1a;
   localparam logic [7:0] MON_SEL_OFS = 8'h1b;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h40;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h41;
   localparam logic [7:0] LOCK_STAT_OFS = 8'h42;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int ABL_LSB = 0;
   localparam int STATUS_SEL_LSB = 2;
   localparam int LD_DISABLE_BIT = 3;
   localparam int WIN_RANGE_BIT = 4;
   localparam int LOCK_CNT_LSB = 5;
   localparam int R_DLY_LSB = 0;
   localparam int R_DLY_EN_BIT = 3;
   localparam int N_DLY_LSB = 4;
   localparam int N_DLY_EN_BIT = 7;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] STATUS_SEL_RST = 8'h00;
   localparam logic [7:0] LOCK_CTRL_RST = 8'h00;
   localparam logic [7:0] DELAY_CTRL_RST = 8'h00;
   localparam logic [7:0] LD_SEL_RST = 8'h00;
   localparam logic [7:0] MON_SEL_RST = 8'h00;
   localparam logic [2:0] IRQ_RST = 3'h0;

   // ------------------------------------------------------------------
   // Pin selector codes
   // ------------------------------------------------------------------
   localparam logic [5:0] LD_SEL_DLD = 6'h01;
   localparam logic [5:0] LD_SEL_ALD_N = 6'h02;
   localparam logic [5:0] LD_SEL_ALD_P = 6'h03;
   localparam logic [5:0] LD_SEL_CSRC = 6'h04;
   localparam logic [5:0] STATUS_SEL_DLD = 6'h01;
   localparam logic [5:0] STATUS_SEL_CMP_H = 6'h02;
   localparam logic [5:0] STATUS_SEL_CMP_L = 6'h03;
   localparam logic [4:0] MON_SEL_DLD = 5'h01;
   localparam logic [4:0] MON_SEL_CMP_H = 5'h02;
   localparam logic [4:0] MON_SEL_CMP_L = 5'h03;

   // ------------------------------------------------------------------
   // Timing: edge gap thresholds in ps, counts of ref_clk cycles
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 25000;
   localparam int LOCK_WIN_LO_PS = 50000;
   localparam int LOCK_WIN_HI_PS = 100000;
   localparam int UNLOCK_EXTRA_PS = 50000;
   localparam int ABL_STEP_PS = 25000;
   localparam int LOCK_WIN_LO_CYC = LOCK_WIN_LO_PS / CLK_PERIOD_PS;
   localparam int LOCK_WIN_HI_CYC = LOCK_WIN_HI_PS / CLK_PERIOD_PS;
   localparam int UNLOCK_EXTRA_CYC = UNLOCK_EXTRA_PS / CLK_PERIOD_PS;
   localparam int ABL_STEP_CYC = ABL_STEP_PS / CLK_PERIOD_PS;
   localparam int CSRC_QUAL_CYC = 64;
   localparam int ALD_PULSE_CYC = 2;
   localparam int LOCK_CNT_5 = 5;
   localparam int LOCK_CNT_16 = 16;
   localparam int LOCK_CNT_64 = 64;
   localparam int LOCK_CNT_255 = 255;
   localparam int GAP_W = 8;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [2:0] r_dly;
      logic r_dly_en;
      logic [2:0] n_dly;
      logic n_dly_en;
   } delay_ctrl_t;

   typedef struct packed {
      logic lock_indicator_pin;
      logic status_pin;
      logic reference_monitor_pin;
   } pins_t;

endpackage

// ---- hdl/pll_lock_detect.sv ----
// Digital phase lock detector, indicator pin routing and divider path delay controls
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps

// Overview of operation
// R1 - Reference and feedback paths get enableable 3-bit delays
// R2 - Lock flag routable to indicator, status, monitor pins
// R3 - Lock after programmed consecutive in-window cycles
// R4 - Lock holds until one cycle exceeds unlock threshold
// R5 - Unlock threshold wider than lock threshold
// R6 - Window set by range bit, antibacklash, counter
// R7 - Detector period must exceed unlock threshold
// R8 - Pulse lock output selectable in both polarities
// R9 - Indicator selector field activates current-source mode
// R10 - Qualified lock rises after continuous flag; restarts
// R11 - Comparator result on monitor or status, both polarities
// R12 - Counter code zero requires five cycles
// R13 - Selector code 000100b picks current-source mode
// R14 - Lock detection runs only with disable bit zero
// R15 - Before lock, out-of-window cycle restarts counter
module pll_lock_detect (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic ref_edge_pin,
   input wire logic fb_edge_pin,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic irq,
   output lock_detect_pkg::delay_ctrl_t delay_ctrl,
   output lock_detect_pkg::pins_t pins_out,
   output logic ld_pin_oe
);

   // ------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------
   logic [1:0] ref_sync_q;
   logic [1:0] fb_sync_q;
   logic ref_prev_q;
   logic fb_prev_q;
   logic ref_rise;
   logic fb_rise;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ref_sync_q <= 2'h0;
         fb_sync_q <= 2'h0;
         ref_prev_q <= 1'h0;
         fb_prev_q <= 1'h0;
      end else begin
         ref_sync_q <= {ref_sync_q[0], ref_edge_pin};
         fb_sync_q <= {fb_sync_q[0], fb_edge_pin};
         ref_prev_q <= ref_sync_q[1];
         fb_prev_q <= fb_sync_q[1];
      end
   end

   assign ref_rise = ref_sync_q[1] & ~ref_prev_q;
   assign fb_rise = fb_sync_q[1] & ~fb_prev_q;

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   logic [7:0] status_sel_q, status_sel_d;
   logic [7:0] lock_ctrl_q, lock_ctrl_d;
   logic [7:0] delay_ctrl_q, delay_ctrl_d;
   logic [7:0] ld_sel_q, ld_sel_d;
   logic [7:0] mon_sel_q, mon_sel_d;
   logic [2:0] irq_stat_q, irq_stat_d;
   logic [2:0] irq_mask_q, irq_mask_d;
   logic [7:0] reg_rdata_d;
   logic [2:0] irq_event;
   logic lock_q;
   logic qual_q;
   logic cmp_q;

   // Lock counter code to cycle count; used by the counter and its check
   function automatic logic [7:0] lock_target(input logic [1:0] code);
      unique case (code)
         2'h0: lock_target = 8'(lock_detect_pkg::LOCK_CNT_5); // R12
         2'h1: lock_target = 8'(lock_detect_pkg::LOCK_CNT_16);
         2'h2: lock_target = 8'(lock_detect_pkg::LOCK_CNT_64);
         2'h3: lock_target = 8'(lock_detect_pkg::LOCK_CNT_255);
      endcase
   endfunction

   always_comb begin
      status_sel_d = status_sel_q;
      lock_ctrl_d = lock_ctrl_q;
      delay_ctrl_d = delay_ctrl_q;
      ld_sel_d = ld_sel_q;
      mon_sel_d = mon_sel_q;
      irq_mask_d = irq_mask_q;
      irq_stat_d = irq_stat_q;
      reg_rdata_d = 8'h00;
      if (reg_wr) begin
         unique case (reg_addr)
            lock_detect_pkg::STATUS_SEL_OFS: status_sel_d = reg_wdata;
            lock_detect_pkg::LOCK_CTRL_OFS: lock_ctrl_d = reg_wdata;
            lock_detect_pkg::DELAY_CTRL_OFS: delay_ctrl_d = reg_wdata;
            lock_detect_pkg::LD_SEL_OFS: ld_sel_d = {2'h0, reg_wdata[5:0]};
            lock_detect_pkg::MON_SEL_OFS: mon_sel_d = reg_wdata;
            lock_detect_pkg::IRQ_STAT_OFS: irq_stat_d = irq_stat_q & ~reg_wdata[2:0];
            lock_detect_pkg::IRQ_MASK_OFS: irq_mask_d = reg_wdata[2:0];
            default: ;
         endcase
      end
      // Set wins over a same-cycle clear
      irq_stat_d = irq_stat_d | irq_event;
      if (reg_rd) begin
         unique case (reg_addr)
            lock_detect_pkg::STATUS_SEL_OFS: reg_rdata_d = status_sel_q;
            lock_detect_pkg::LOCK_CTRL_OFS: reg_rdata_d = lock_ctrl_q;
            lock_detect_pkg::DELAY_CTRL_OFS: reg_rdata_d = delay_ctrl_q;
            lock_detect_pkg::LD_SEL_OFS: reg_rdata_d = ld_sel_q;
            lock_detect_pkg::MON_SEL_OFS: reg_rdata_d = mon_sel_q;
            lock_detect_pkg::IRQ_STAT_OFS: reg_rdata_d = {5'h00, irq_stat_q};
            lock_detect_pkg::IRQ_MASK_OFS: reg_rdata_d = {5'h00, irq_mask_q};
            lock_detect_pkg::LOCK_STAT_OFS: reg_rdata_d = {5'h00, cmp_q, qual_q, lock_q};
            default: reg_rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         status_sel_q <= lock_detect_pkg::STATUS_SEL_RST;
         lock_ctrl_q <= lock_detect_pkg::LOCK_CTRL_RST;
         delay_ctrl_q <= lock_detect_pkg::DELAY_CTRL_RST;
         ld_sel_q <= lock_detect_pkg::LD_SEL_RST;
         mon_sel_q <= lock_detect_pkg::MON_SEL_RST;
         irq_stat_q <= lock_detect_pkg::IRQ_RST;
         irq_mask_q <= lock_detect_pkg::IRQ_RST;
         reg_rdata <= 8'h00;
         irq <= 1'h0;
         delay_ctrl <= '0;
      end else begin
         status_sel_q <= status_sel_d;
         lock_ctrl_q <= lock_ctrl_d;
         delay_ctrl_q <= delay_ctrl_d;
         ld_sel_q <= ld_sel_d;
         mon_sel_q <= mon_sel_d;
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
         reg_rdata <= reg_rdata_d;
         irq <= |(irq_stat_d & irq_mask_d);
         // Each path delay is passed out ungated, beside its own enable bit
         delay_ctrl.r_dly <= delay_ctrl_d[lock_detect_pkg::R_DLY_LSB +: 3]; // R1
         delay_ctrl.r_dly_en <= delay_ctrl_d[lock_detect_pkg::R_DLY_EN_BIT]; // R1
         delay_ctrl.n_dly <= delay_ctrl_d[lock_detect_pkg::N_DLY_LSB +: 3]; // R1
         delay_ctrl.n_dly_en <= delay_ctrl_d[lock_detect_pkg::N_DLY_EN_BIT]; // R1
      end
   end

   // ------------------------------------------------------------------
   // Edge gap measurement and lock decision
   // ------------------------------------------------------------------
   // Gap counter runs from the first edge of a pair to the second; a pair that never
   // completes saturates and counts as out of window (the period must exceed it, R7)
   logic [lock_detect_pkg::GAP_W-1:0] gap_q, gap_d;
   logic pend_q, pend_d;
   logic [7:0] cnt_q, cnt_d;
   logic lock_d;
   logic cycle_done;
   logic [lock_detect_pkg::GAP_W-1:0] gap_meas;
   logic [lock_detect_pkg::GAP_W-1:0] lock_thr;
   logic [lock_detect_pkg::GAP_W-1:0] unlock_thr;
   logic ld_enable;

   // Window range bit set narrows both windows; antibacklash width widens both
   assign lock_thr = lock_detect_pkg::GAP_W'(lock_ctrl_q[lock_detect_pkg::WIN_RANGE_BIT] ?
      lock_detect_pkg::LOCK_WIN_LO_CYC : lock_detect_pkg::LOCK_WIN_HI_CYC)
      + lock_detect_pkg::GAP_W'(status_sel_q[lock_detect_pkg::ABL_LSB +: 2]) *
      lock_detect_pkg::GAP_W'(lock_detect_pkg::ABL_STEP_CYC); // R6
   assign unlock_thr = lock_thr +
      lock_detect_pkg::GAP_W'(lock_detect_pkg::UNLOCK_EXTRA_CYC); // R5
   assign ld_enable = ~lock_ctrl_q[lock_detect_pkg::LD_DISABLE_BIT]; // R14

   always_comb begin
      gap_d = gap_q;
      pend_d = pend_q;
      gap_meas = pend_q ? gap_q : '0;
      // An edge closes an open pair; two edges in one cycle are a zero gap pair
      cycle_done = (ref_rise | fb_rise) & (pend_q | (ref_rise & fb_rise));
      if (ref_rise | fb_rise) begin
         pend_d = ~pend_q & ~(ref_rise & fb_rise);
         // One cycle has already passed when the closing edge is seen
         gap_d = lock_detect_pkg::GAP_W'(1);
      end else if (pend_q && gap_q != '1) begin
         gap_d = gap_q + 1'b1;
      end
   end

   always_comb begin
      cnt_d = cnt_q;
      lock_d = lock_q;
      if (!ld_enable) begin
         cnt_d = 8'h00;
         lock_d = 1'b0;
      end else if (cycle_done) begin
         if (lock_q) begin
            lock_d = (gap_meas <= unlock_thr); // R4
         end else if (gap_meas >= lock_thr) begin
            cnt_d = 8'h00; // R15
         end else if (cnt_q + 8'h01 >=
            lock_target(lock_ctrl_q[lock_detect_pkg::LOCK_CNT_LSB +: 2])) begin
            lock_d = 1'b1; // R3
            cnt_d = 8'h00;
         end else begin
            cnt_d = cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         gap_q <= '0;
         pend_q <= 1'b0;
         cnt_q <= 8'h00;
         lock_q <= 1'b0;
      end else begin
         gap_q <= gap_d;
         pend_q <= pend_d;
         cnt_q <= cnt_d;
         lock_q <= lock_d;
      end
   end

   AST_LOCK_NEEDS_COUNT: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(lock_q) |-> $past(cnt_q) + 8'h01 >=
      lock_target($past(lock_ctrl_q[lock_detect_pkg::LOCK_CNT_LSB +: 2])))
      else $error("Lock declared before enough in-window cycles"); // R3
   AST_UNLOCK_ONE_CYCLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (lock_q && ld_enable && cycle_done && gap_meas > unlock_thr) |=> !lock_q)
      else $error("Lock not dropped on out-of-window cycle"); // R4
   AST_UNLOCK_WIDER: assert property (@(posedge ref_clk) disable iff (!reset_n)
      unlock_thr > lock_thr) else $error("Unlock window not wider than lock window"); // R5
   AST_RESTART: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (!lock_q && cycle_done && gap_meas >= lock_thr) |=> cnt_q == 8'h00 && !lock_q)
      else $error("Counter not restarted on out-of-window cycle"); // R15
   AST_DISABLED: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !ld_enable |=> !lock_q) else $error("Lock shown while detection disabled"); // R14

   // ------------------------------------------------------------------
   // Current-source qualification, pulse output, comparator, pin muxes
   // ------------------------------------------------------------------
   logic [7:0] qual_cnt_q, qual_cnt_d;
   logic qual_d;
   logic [1:0] ald_cnt_q, ald_cnt_d;
   logic ald_pulse;
   lock_detect_pkg::pins_t pins_d;
   logic oe_d;
   logic csrc_mode;

   assign csrc_mode = ld_sel_q[5:0] == lock_detect_pkg::LD_SEL_CSRC; // R9 R13

   always_comb begin
      qual_cnt_d = qual_cnt_q;
      qual_d = qual_q;
      ald_cnt_d = ald_cnt_q;
      // Any momentary false discharges at once, as the pin capacitor does
      if (!lock_q || !csrc_mode) begin // R10
         qual_cnt_d = 8'h00;
         qual_d = 1'b0;
      end else if (qual_cnt_q >= 8'(lock_detect_pkg::CSRC_QUAL_CYC - 1)) begin
         qual_d = 1'b1; // R10
      end else begin
         qual_cnt_d = qual_cnt_q + 8'h01;
      end
      // Short pulse per detector cycle while out of lock
      if (cycle_done && !lock_q) begin
         ald_cnt_d = 2'(lock_detect_pkg::ALD_PULSE_CYC);
      end else if (ald_cnt_q != 2'h0) begin
         ald_cnt_d = ald_cnt_q - 2'h1;
      end
   end

   assign ald_pulse = ald_cnt_q != 2'h0;

   always_comb begin
      pins_d = '0;
      oe_d = 1'b1;
      irq_event = {~lock_d & lock_q, lock_d & ~lock_q, qual_d & ~qual_q};
      unique case (ld_sel_q[5:0])
         lock_detect_pkg::LD_SEL_DLD: pins_d.lock_indicator_pin = lock_q; // R2
         lock_detect_pkg::LD_SEL_ALD_N, lock_detect_pkg::LD_SEL_ALD_P: begin
            // Driven only during a pulse; the external resistor holds the idle level
            pins_d.lock_indicator_pin = (ld_sel_q[5:0] == lock_detect_pkg::LD_SEL_ALD_P); // R8
            oe_d = ald_pulse;
         end
         lock_detect_pkg::LD_SEL_CSRC: pins_d.lock_indicator_pin = qual_q; // R9
         default: pins_d.lock_indicator_pin = 1'b0;
      endcase
      unique case (status_sel_q[lock_detect_pkg::STATUS_SEL_LSB +: 6])
         lock_detect_pkg::STATUS_SEL_DLD: pins_d.status_pin = lock_q; // R2
         lock_detect_pkg::STATUS_SEL_CMP_H: pins_d.status_pin = cmp_q; // R11
         lock_detect_pkg::STATUS_SEL_CMP_L: pins_d.status_pin = ~cmp_q; // R11
         default: pins_d.status_pin = 1'b0;
      endcase
      unique case (mon_sel_q[4:0])
         lock_detect_pkg::MON_SEL_DLD: pins_d.reference_monitor_pin = lock_q; // R2
         lock_detect_pkg::MON_SEL_CMP_H: pins_d.reference_monitor_pin = cmp_q; // R11
         lock_detect_pkg::MON_SEL_CMP_L: pins_d.reference_monitor_pin = ~cmp_q; // R11
         default: pins_d.reference_monitor_pin = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         qual_cnt_q <= 8'h00;
         qual_q <= 1'b0;
         ald_cnt_q <= 2'h0;
         cmp_q <= 1'b0;
         pins_out <= '0;
         ld_pin_oe <= 1'b0;
      end else begin
         qual_cnt_q <= qual_cnt_d;
         qual_q <= qual_d;
         ald_cnt_q <= ald_cnt_d;
         // Comparator models the pin voltage crossing: qualified lock
         cmp_q <= qual_q;
         pins_out <= pins_d;
         ld_pin_oe <= oe_d;
      end
   end

   AST_QUAL_RESET: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (!lock_q) |=> !qual_q) else $error("Qualified lock survived a false flag"); // R10
   AST_CSRC_ONLY: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(qual_q) |-> $past(csrc_mode) && $past(lock_q))
      else $error("Qualified lock outside current-source mode"); // R9
   AST_STATUS_CMP_LOW: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (status_sel_q[lock_detect_pkg::STATUS_SEL_LSB +: 6] == lock_detect_pkg::STATUS_SEL_CMP_L
      && $stable(status_sel_q)) |=> pins_out.status_pin == !$past(cmp_q))
      else $error("Status pin not inverted comparator"); // R11

endmodule // pll_lock_detect

// ---- sim/edge_source.sv ----
// Detector edge source: reference and feedback rising edges a set gap apart
`timescale 1ns/100ps
module edge_source #(
   parameter int PERIOD = 32
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic run,
   input wire logic [4:0] gap,
   output logic ref_edge_pin,
   output logic fb_edge_pin
);
   // ---------------------------------------------------------------
   // Edge pair generator
   // ---------------------------------------------------------------
   // Period stays well above the widest unlock window (9 cycles), else pairing slips
   logic [7:0] cnt_q;
   logic [4:0] gap_q;
   logic [7:0] gap_now;
   // Gap is taken at the start of each period so a pair never mixes two settings
   assign gap_now = (cnt_q == 8'h00) ? {3'h0, gap} : {3'h0, gap_q};
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 8'h00;
         gap_q <= 5'h00;
         ref_edge_pin <= 1'b0;
         fb_edge_pin <= 1'b0;
      end else if (!run) begin
         cnt_q <= 8'h00;
         ref_edge_pin <= 1'b0;
         fb_edge_pin <= 1'b0;
      end else begin
         if (cnt_q == 8'h00) begin
            gap_q <= gap;
         end
         ref_edge_pin <= (cnt_q < 8'h04);
         fb_edge_pin <= (cnt_q >= gap_now) && (cnt_q < gap_now + 8'h04);
         cnt_q <= (cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
      end
   end
endmodule // edge_source

// ---- sim/test_pll_lock_detect.sv ----
// Self-checking testbench for the lock detector
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_pll_lock_detect;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic ref_edge_pin;
   logic fb_edge_pin;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic irq;
   lock_detect_pkg::delay_ctrl_t delay_ctrl;
   lock_detect_pkg::pins_t pins_out;
   logic ld_pin_oe;
   logic run = 1'b0;
   logic [4:0] gap = 5'h00;
   logic [7:0] d;
   int error_cnt = 0;
   int checks_done = 0;

   always #12.5 ref_clk = ~ref_clk;

   pll_lock_detect i_pll_lock_detect (.ref_clk(ref_clk), .reset_n(reset_n),
      .ref_edge_pin(ref_edge_pin), .fb_edge_pin(fb_edge_pin), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq(irq), .delay_ctrl(delay_ctrl), .pins_out(pins_out), .ld_pin_oe(ld_pin_oe));
   edge_source #(.PERIOD(32)) i_edge_source (.ref_clk(ref_clk), .reset_n(reset_n),
      .run(run), .gap(gap), .ref_edge_pin(ref_edge_pin), .fb_edge_pin(fb_edge_pin));

   // ---------------------------------------------------------------
   // Bus and stimulus helpers
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   // Runs n detector pairs at the given gap, returning once the last pair has landed
   task automatic pairs(input int n, input logic [4:0] g);
      @(posedge ref_clk);
      gap <= g;
      run <= 1'b1;
      repeat (n) @(posedge ref_edge_pin);
      repeat (int'(g) + 10) @(posedge ref_clk);
   endtask

   task automatic lock_is(input logic e);
      rd(lock_detect_pkg::LOCK_STAT_OFS, d);
      `CHK("lock flag", e, d[0])
   endtask

   task automatic wire_count(input logic pol, output int n);
      n = 0;
      repeat (64) begin
         @(posedge ref_clk);
         // Released pin settles to its resistor: high for n-drain, low for p-drain
         #1 if ((ld_pin_oe ? pins_out.lock_indicator_pin : ~pol) === pol) n++;
      end
   endtask

   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic test_reset;
      rd(lock_detect_pkg::STATUS_SEL_OFS, d);
      `CHK("status sel", lock_detect_pkg::STATUS_SEL_RST, d)
      rd(lock_detect_pkg::LOCK_CTRL_OFS, d);
      `CHK("lock ctrl", lock_detect_pkg::LOCK_CTRL_RST, d)
      rd(lock_detect_pkg::LD_SEL_OFS, d);
      `CHK("ld sel", lock_detect_pkg::LD_SEL_RST, d)
      rd(lock_detect_pkg::MON_SEL_OFS, d);
      `CHK("mon sel", lock_detect_pkg::MON_SEL_RST, d)
      rd(8'h55, d);
      `CHK("unmapped", 8'h00, d)
      `CHK("pins", 3'h0, pins_out)
      wr(lock_detect_pkg::LD_SEL_OFS, 8'h01);
      wr(lock_detect_pkg::STATUS_SEL_OFS, 8'h04);
      wr(lock_detect_pkg::MON_SEL_OFS, 8'h01);
      wr(lock_detect_pkg::LOCK_CTRL_OFS, 8'h00);
      wr(lock_detect_pkg::IRQ_MASK_OFS, 8'h02);
      $display("test_reset done");
   endtask

   task automatic test_delay;
      logic [7:0] v;
      for (int i = 0; i < 2; i++) begin
         v = (i == 0) ? 8'hd9 : 8'h26;
         wr(lock_detect_pkg::DELAY_CTRL_OFS, v);
         rd(lock_detect_pkg::DELAY_CTRL_OFS, d);
         `CHK("delay reg", v, d)
         `CHK("r delay", v[2:0], delay_ctrl.r_dly)
         `CHK("r enable", v[3], delay_ctrl.r_dly_en)
         `CHK("n delay", v[6:4], delay_ctrl.n_dly)
         `CHK("n enable", v[7], delay_ctrl.n_dly_en)
      end
      $display("test_delay done");
   endtask

   task automatic test_lock;
      pairs(4, 5'h01);
      lock_is(1'b0);
      pairs(1, 5'h01);
      lock_is(1'b1);
      `CHK("pins locked", 3'h7, pins_out)
      `CHK("irq", 1'b1, irq)
      wr(lock_detect_pkg::IRQ_STAT_OFS, 8'h02);
      @(posedge ref_clk);
      #1 `CHK("irq cleared", 1'b0, irq)
      pairs(3, 5'h05);
      lock_is(1'b1);
      pairs(1, 5'h0a);
      lock_is(1'b0);
      `CHK("pins unlocked", 3'h0, pins_out)
      pairs(3, 5'h01);
      pairs(1, 5'h05);
      pairs(4, 5'h01);
      lock_is(1'b0);
      pairs(1, 5'h01);
      lock_is(1'b1);
      $display("test_lock done");
   endtask

   task automatic test_window;
      wr(lock_detect_pkg::LOCK_CTRL_OFS, 8'h10);
      pairs(1, 5'h0a);
      pairs(6, 5'h03);
      lock_is(1'b0);
      wr(lock_detect_pkg::STATUS_SEL_OFS, 8'h06);
      pairs(5, 5'h03);
      lock_is(1'b1);
      wr(lock_detect_pkg::LOCK_CTRL_OFS, 8'h30);
      pairs(1, 5'h0a);
      pairs(15, 5'h03);
      lock_is(1'b0);
      pairs(1, 5'h03);
      lock_is(1'b1);
      for (int i = 2; i < 4; i++) begin
         wr(lock_detect_pkg::LOCK_CTRL_OFS, 8'(i << lock_detect_pkg::LOCK_CNT_LSB));
         pairs(1, 5'h0a);
         pairs(((i == 2) ? lock_detect_pkg::LOCK_CNT_64 : lock_detect_pkg::LOCK_CNT_255) - 1,
            5'h03);
         lock_is(1'b0);
         pairs(1, 5'h03);
         lock_is(1'b1);
      end
      wr(lock_detect_pkg::STATUS_SEL_OFS, 8'h04);
      wr(lock_detect_pkg::LOCK_CTRL_OFS, 8'h08);
      repeat (4) @(posedge ref_clk);
      lock_is(1'b0);
      wr(lock_detect_pkg::LOCK_CTRL_OFS, 8'h00);
      pairs(5, 5'h01);
      lock_is(1'b1);
      $display("test_window done");
   endtask

   task automatic test_pulse;
      int n;
      // Pulses only come while out of lock
      pairs(1, 5'h0a);
      wr(lock_detect_pkg::LD_SEL_OFS, 8'h02);
      wire_count(1'b0, n);
      `CHK("n-drain lows", 1'b1, (n > 0 && n < 32))
      wr(lock_detect_pkg::LD_SEL_OFS, 8'h03);
      wire_count(1'b1, n);
      `CHK("p-drain highs", 1'b1, (n > 0 && n < 32))
      $display("test_pulse done");
   endtask

   task automatic test_csrc;
      wr(lock_detect_pkg::STATUS_SEL_OFS, 8'h08);
      wr(lock_detect_pkg::MON_SEL_OFS, 8'h03);
      pairs(1, 5'h0a);
      wr(lock_detect_pkg::LD_SEL_OFS, 8'h04);
      pairs(5, 5'h01);
      repeat (40) @(posedge ref_clk);
      rd(lock_detect_pkg::LOCK_STAT_OFS, d);
      `CHK("qual early", 1'b0, d[1])
      `CHK("ld early", 1'b0, pins_out.lock_indicator_pin)
      `CHK("mon early", 1'b1, pins_out.reference_monitor_pin)
      repeat (40) @(posedge ref_clk);
      rd(lock_detect_pkg::LOCK_STAT_OFS, d);
      `CHK("qual late", 1'b1, d[1])
      `CHK("ld qualified", 1'b1, pins_out.lock_indicator_pin)
      `CHK("status cmp", 1'b1, pins_out.status_pin)
      `CHK("mon cmp", 1'b0, pins_out.reference_monitor_pin)
      // Swap polarities so each comparator code is seen on each pin
      wr(lock_detect_pkg::STATUS_SEL_OFS, 8'h0c);
      wr(lock_detect_pkg::MON_SEL_OFS, 8'h02);
      @(posedge ref_clk);
      #1 `CHK("status cmp low", 1'b0, pins_out.status_pin)
      `CHK("mon cmp high", 1'b1, pins_out.reference_monitor_pin)
      pairs(1, 5'h0a);
      #1 `CHK("ld dropped", 1'b0, pins_out.lock_indicator_pin)
      `CHK("status dropped", 1'b1, pins_out.status_pin)
      `CHK("mon dropped", 1'b0, pins_out.reference_monitor_pin)
      $display("test_csrc done");
   endtask

   initial begin
      repeat (40000) @(posedge ref_clk);
      error_cnt++;
      finish_test();
   end

   initial begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      test_reset();
      test_delay();
      test_lock();
      test_window();
      test_pulse();
      test_csrc();
      finish_test();
   end
endmodule // test_pll_lock_detect
